// *** hw/cst_pkg.sv ***
// Constants and types shared by the charge supervisor design files.
package cst_pkg;
  // Clock rate and the cycle counts derived from it.
  localparam int CLK_MHZ        = 250;
  localparam int TICK_MS        = 1000;
  localparam int TICK_CYCLES    = TICK_MS * 1000 * CLK_MHZ;
  localparam int PULSE_US       = 256;
  localparam int PULSE_CYCLES   = PULSE_US * CLK_MHZ;
  // Safety timer limits in hours and in one-second ticks.
  localparam int HOUR_S         = 3600;
  localparam int SHORT_HOURS    = 2;
  localparam int LONG_HOURS     = 16;
  localparam int CUT_HOURS      = 7;
  localparam int TICKS_PER_HOUR = HOUR_S * 1000 / TICK_MS;
  localparam logic [16:0] SHORT_LIMIT = 17'(SHORT_HOURS * TICKS_PER_HOUR);
  localparam logic [16:0] LONG_LIMIT  = 17'(LONG_HOURS * TICKS_PER_HOUR);
  localparam logic [16:0] CUT_LIMIT   = 17'(CUT_HOURS * TICKS_PER_HOUR);
  // Register byte offsets.
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] ZONE_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS  = 8'h08;
  localparam logic [7:0] TIMER_OFS = 8'h0c;
  // Reset values; the minimum system voltage code 5 stands for 3.5V.
  localparam logic [5:0]  CTRL_RST   = 6'h1f;
  localparam logic [2:0]  SYSMIN_3V5 = 3'h5;
  localparam logic [12:0] ZONE_RST   = {SYSMIN_3V5, 10'h152};
  // Field codes.
  localparam logic [2:0] NTC_NORMAL  = 3'h0;
  localparam logic [2:0] NTC_COLD    = 3'h5;
  localparam logic [2:0] NTC_HOT     = 3'h6;
  localparam logic [1:0] FAULT_NONE  = 2'h0;
  localparam logic [1:0] FAULT_TIMER = 2'h3;
  localparam logic [2:0] SRC_NONE    = 3'h0;
  localparam logic [2:0] SRC_BOOST   = 3'h7;

  typedef enum logic [2:0] {ZONE_COLD, ZONE_COOL, ZONE_NORMAL, ZONE_WARM,
                            ZONE_HOT} cst_zone_type;
  typedef enum logic [1:0] {ISCALE_FULL, ISCALE_HALF, ISCALE_FIFTH,
                            ISCALE_ZERO} cst_iscale_type;
  typedef enum logic [1:0] {CHG_IDLE, CHG_RUN, CHG_SUSPEND,
                            CHG_EXPIRED} cst_chg_state_type;

  // Control register, bit 0 last.
  typedef struct packed {
    logic boost_enable;
    logic zone_limit_enable;
    logic timer_slowdown_enable;
    logic long_timer_select;
    logic timer_enable;
    logic charge_config_bit;
  } cst_ctrl_type;

  // Zone and system settings register, bit 0 last.
  typedef struct packed {
    logic [2:0] min_system_voltage_setting;
    logic [1:0] warm_threshold_select;
    logic [1:0] cool_threshold_select;
    logic       cool_voltage_select;
    logic       cool_current_enable;
    logic       cool_current_select;
    logic [1:0] warm_current_select;
    logic       warm_voltage_select;
  } cst_zone_cfg_type;

  // Status register, bit 0 last.
  typedef struct packed {
    logic         boost_on;
    logic         charging;
    cst_zone_type zone;
    logic         input_voltage_limit_status;
    logic         input_current_limit_status;
    logic         system_regulation_status;
    logic [2:0]   input_source_status;
    logic [2:0]   thermistor_fault_field;
    logic [1:0]   charge_fault_field;
  } cst_status_type;

  // Comparator and regulation inputs from the analog side.
  typedef struct packed {
    logic       charge_enable_pin_low;
    logic [3:0] warmer_than;
    logic [1:0] boost_warmer;
    logic       vindpm;
    logic       iindpm;
    logic       thermal_reg;
    logic       supplement;
    logic       sysmin_reg;
    logic       vbat_above_low;
    logic       ext_fault;
    logic       restart_req;
    logic       vbat_below_programmed_charge_voltage;
    logic [2:0] source_type;
  } cst_pins_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cst_bus_req_type;

  // Targets handed to the analog loops.
  typedef struct packed {
    logic           charging;
    cst_iscale_type iscale;
    logic           programmed_charge_voltage_clamp_4v1;
    logic           boost_on;
    logic [1:0]     cool_threshold_select;
    logic [1:0]     warm_threshold_select;
    logic [2:0]     min_system_voltage_setting;
  } cst_drive_type;
endpackage

// *** hw/cst_safety_timer.sv ***
// Charge safety timer with one-second prescaler and half-rate mode.
`timescale 1ns/1ps
module cst_safety_timer
  import cst_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clear,
  input  wire logic        hold,
  input  wire logic        slow,
  input  wire logic [16:0] limit,
  output logic             expired,
  output logic [16:0]      count
);
  localparam logic [27:0] TICK_LAST = 28'(TICK_CYCLES_P - 1);

  typedef struct packed {
    logic [27:0] pre;
    logic        half;
    logic [16:0] count;
    logic        expired;
  } cst_timer_state_type;

  cst_timer_state_type st;
  cst_timer_state_type next_st;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Hold freezes the prescaler too, so a pause loses no part of a tick.
  always_comb
  begin
    next_st = st;
    next_st.expired = 1'b0;
    if (clear)
      next_st = '0;
    else if (!hold)
    begin
      if (st.count >= limit)
        next_st.expired = 1'b1;
      else if (st.pre == TICK_LAST)
      begin
        next_st.pre = '0;
        next_st.half = slow && !st.half; // RULE23
        if (!slow || st.half)
        begin
          next_st.count = st.count + 17'h1;
          next_st.expired = (st.count + 17'h1) >= limit;
        end
      end
      else
        next_st.pre = st.pre + 28'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  assign expired = st.expired;
  assign count   = st.count;

  half_rate_skip_a: // RULE23
    assert property (!clear && !hold && slow && !st.half &&
                     st.pre == TICK_LAST && st.count < limit
                     |=> st.half && st.count == $past(st.count))
    else $error("Slow tick advanced the timer.");
endmodule

// *** hw/cst_int_pulse.sv ***
// Low-going host interrupt pulse with one pending request.
`timescale 1ns/1ps
module cst_int_pulse
  import cst_pkg::*;
#(
  parameter int PULSE_CYCLES_P = PULSE_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic event_in,
  output logic      pulse_n
);
  localparam logic [15:0] CNT_LOAD = 16'(PULSE_CYCLES_P);

  typedef struct packed {
    logic [15:0] cnt;
    logic        pend;
    logic        out_n;
  } cst_pulse_state_type;

  cst_pulse_state_type st;
  cst_pulse_state_type next_st;
  logic [15:0]         low_len;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Events during a pulse merge into one follow-up pulse, never lost.
  always_comb
  begin
    next_st = st;
    if (st.cnt != '0)
    begin
      next_st.cnt = st.cnt - 16'h1;
      next_st.out_n = (st.cnt == 16'h1);
      if (event_in)
        next_st.pend = 1'b1;
    end
    else if (event_in || st.pend)
    begin
      next_st.cnt = CNT_LOAD; // RULE22
      next_st.out_n = 1'b0;
      next_st.pend = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      st <= '{cnt: '0, pend: 1'b0, out_n: 1'b1};
    else
      st <= next_st;
  end

  // Length of the present low phase, read only by the check below.
  always_ff @(posedge clk)
  begin
    if (!rstn || st.out_n)
      low_len <= '0;
    else
      low_len <= low_len + 16'h1;
  end

  assign pulse_n = st.out_n;

  pulse_width_a: // RULE22
    assert property ($rose(st.out_n) |-> low_len == CNT_LOAD)
    else $error("Interrupt pulse has the wrong width.");
endmodule

// *** hw/cst_charge_supervisor.sv ***
// Charge supervisor: temperature zones, boost guard and safety timer.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: New charge cycle starts only with temperature inside cold-to-hot window.
// RULE2: Leaving the window while charging suspends at zero current.
// RULE3: Warm zone clamps voltage to 4.1V unless warm voltage select set.
// RULE4: Warm zone current scales to 0, 20 or 50 percent by select; code also gives full current for select 3.
// RULE5: Cool zone current 50 or 20 percent if enabled, else zero.
// RULE6: Cool zone clamps voltage to 4.1V only when cool voltage select set.
// RULE7: Cool and warm thresholds each have their own two-bit select.
// RULE8: Zone limiting can be switched off entirely.
// RULE9: Boost outside its window suspends, source status 000, fault reported.
// RULE10: Boost resumes inside window and thermistor fault returns to 000.
// RULE11: Timer expiry stops charging, fault field 11, interrupt pulse.
// RULE12: Limit is 2 hours until battery passed low threshold, then 16.
// RULE13: Long select clear gives 7 hours; timer enable clear disables timer.
// RULE14: Timer runs half rate under input limits, cool zone or thermal.
// RULE15: Slowdown enable clear keeps the timer at full rate.
// RULE16: Timer holds during faults, supplement mode or suspension.
// RULE17: Restart or charge enable toggle resets the timer to zero.
// RULE18: Three-bit minimum system voltage setting, default 3.5V.
// RULE19: System regulation status follows minimum system regulation.
// RULE20: Input current and voltage limit status bits follow the loops.
// RULE21: Charging needs configuration bit 1 and enable pin low; code needs charge_enable_pin_low clear.
// RULE22: Each interrupt is one low pulse of 256 microseconds.
// RULE23: Half rate counts only every second tick.
// RULE24: Ordered comparators decode to exactly one temperature zone.
module cst_charge_supervisor
  import cst_pkg::*;
#(
  parameter int TICK_CYCLES_P  = TICK_CYCLES,
  parameter int PULSE_CYCLES_P = PULSE_CYCLES
)
(
  input  wire logic            clk,
  input  wire logic            rstn,
  input  wire cst_bus_req_type bus,
  output logic [31:0]          bus_rdata,
  input  wire cst_pins_type    pins,
  output cst_drive_type        drive,
  output logic                 host_interrupt_pulse_out_n
);
  typedef struct packed {
    cst_pins_type      sync1;
    cst_pins_type      sync2;
    logic              allowed_prev;
    logic              restart_prev;
    logic              vbat_rose;
    logic              timer_fault;
    logic              int_ev;
    cst_chg_state_type chg;
    cst_ctrl_type      ctrl;
    cst_zone_cfg_type  zcfg;
    cst_status_type    status;
    logic              charging;
    cst_iscale_type    iscale;
    logic              programmed_charge_voltage_clamp_4v1;
    logic              boost_on;
    logic [31:0]       rdata;
  } cst_main_state_type;

  cst_main_state_type st;
  cst_main_state_type next_st;
  cst_zone_type       zone_c;
  logic               win_ok;
  logic               chg_allowed;
  logic               new_cycle;
  logic               boost_ok;
  logic               t_clear;
  logic               t_hold;
  logic               t_slow;
  logic [16:0]        t_limit;
  logic               t_expired;
  logic [16:0]        t_count;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Comparators are ordered, so the first one not passed names the zone.
  function automatic cst_zone_type decode_zone(input logic [3:0] w);
    cst_zone_type z;
    if (!w[0])
      z = ZONE_COLD;
    else if (!w[1])
      z = ZONE_COOL;
    else if (!w[2])
      z = ZONE_NORMAL;
    else if (!w[3])
      z = ZONE_WARM;
    else
      z = ZONE_HOT;
    return z;
  endfunction

  // Current target for a zone while charging.
  function automatic cst_iscale_type scale_of(input cst_zone_type z,
                                              input cst_zone_cfg_type c);
    cst_iscale_type s;
    s = ISCALE_FULL;
    if (z == ZONE_COOL)
    begin
      if (!c.cool_current_enable)
        s = ISCALE_ZERO; // RULE5
      else
        s = c.cool_current_select ? ISCALE_FIFTH : ISCALE_HALF; // RULE5
    end
    else if (z == ZONE_WARM)
    begin
      unique case (c.warm_current_select) // RULE4
        2'h0: s = ISCALE_ZERO;
        2'h1: s = ISCALE_FIFTH;
        2'h2: s = ISCALE_HALF;
        2'h3: s = ISCALE_FULL;
      endcase
    end
    return s;
  endfunction

  always_comb
  begin
    cst_pins_type p;
    logic         ntc_change;
    p = st.sync2;
    ntc_change = 1'b0;
    next_st = st;

    // Two-stage synchroniser for the analog comparator levels.
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;

    // Zone decode; with limiting off every temperature counts as normal.
    zone_c = st.ctrl.zone_limit_enable ? decode_zone(p.warmer_than)
                                       : ZONE_NORMAL; // RULE8 RULE24
    win_ok = (zone_c != ZONE_COLD) && (zone_c != ZONE_HOT);
    chg_allowed = st.ctrl.charge_config_bit &&
                  !p.charge_enable_pin_low; // RULE21
    new_cycle = (chg_allowed && !st.allowed_prev) ||
                (p.restart_req && !st.restart_prev); // RULE17
    boost_ok = p.boost_warmer[0] && !p.boost_warmer[1];
    next_st.allowed_prev = chg_allowed;
    next_st.restart_prev = p.restart_req;

    // Charge cycle sequencing.
    unique case (st.chg)
      CHG_IDLE:
        if (chg_allowed && win_ok && !st.timer_fault && !p.ext_fault &&
            p.vbat_below_programmed_charge_voltage)
          next_st.chg = CHG_RUN; // RULE1
      CHG_RUN:
        if (t_expired)
          next_st.chg = CHG_EXPIRED; // RULE11
        else if (!win_ok)
          next_st.chg = CHG_SUSPEND; // RULE2
      CHG_SUSPEND:
        if (win_ok)
          next_st.chg = CHG_RUN; // RULE2
      CHG_EXPIRED:
        next_st.chg = CHG_EXPIRED;
    endcase
    if (!chg_allowed || new_cycle)
      next_st.chg = CHG_IDLE; // RULE21

    // Expiry sets the fault; a same-cycle restart does not erase it.
    if (new_cycle)
      next_st.timer_fault = 1'b0;
    if (t_expired)
      next_st.timer_fault = 1'b1; // RULE11

    // The battery counts as past the low threshold once seen above it while charging.
    if (new_cycle)
      next_st.vbat_rose = 1'b0;
    if (st.chg == CHG_RUN && p.vbat_above_low)
      next_st.vbat_rose = 1'b1;

    // Safety timer controls.
    if (!st.vbat_rose)
      t_limit = SHORT_LIMIT; // RULE12
    else if (st.ctrl.long_timer_select)
      t_limit = LONG_LIMIT; // RULE12
    else
      t_limit = CUT_LIMIT; // RULE13
    t_clear = new_cycle || !st.ctrl.timer_enable ||
              st.chg == CHG_IDLE; // RULE13 RULE17
    t_hold = (st.chg != CHG_RUN) || p.ext_fault || p.supplement; // RULE16
    t_slow = st.ctrl.timer_slowdown_enable &&
             (p.vindpm || p.iindpm || p.thermal_reg ||
              zone_c == ZONE_COOL); // RULE14 RULE15

    // Targets for the analog loops, aligned with the charge state.
    next_st.charging = (next_st.chg == CHG_RUN);
    next_st.iscale = next_st.charging ? scale_of(zone_c, st.zcfg)
                                      : ISCALE_ZERO; // RULE2
    next_st.programmed_charge_voltage_clamp_4v1 =
      (zone_c == ZONE_WARM && !st.zcfg.warm_voltage_select) || // RULE3
      (zone_c == ZONE_COOL && st.zcfg.cool_voltage_select); // RULE6
    next_st.boost_on = st.ctrl.boost_enable && boost_ok; // RULE9 RULE10

    // Thermistor fault is real time: boost window in boost, else zones.
    if (st.ctrl.boost_enable)
    begin
      if (boost_ok)
        next_st.status.thermistor_fault_field = NTC_NORMAL; // RULE10
      else if (!p.boost_warmer[0])
        next_st.status.thermistor_fault_field = NTC_COLD; // RULE9
      else
        next_st.status.thermistor_fault_field = NTC_HOT; // RULE9
      next_st.status.input_source_status =
        boost_ok ? SRC_BOOST : SRC_NONE; // RULE9
    end
    else
    begin
      if (zone_c == ZONE_COLD)
        next_st.status.thermistor_fault_field = NTC_COLD;
      else if (zone_c == ZONE_HOT)
        next_st.status.thermistor_fault_field = NTC_HOT;
      else
        next_st.status.thermistor_fault_field = NTC_NORMAL;
      next_st.status.input_source_status = p.source_type;
    end

    // Remaining status fields.
    next_st.status.charge_fault_field =
      next_st.timer_fault ? FAULT_TIMER : FAULT_NONE; // RULE11
    next_st.status.system_regulation_status = p.sysmin_reg; // RULE19
    next_st.status.input_current_limit_status = p.iindpm; // RULE20
    next_st.status.input_voltage_limit_status = p.vindpm; // RULE20
    next_st.status.zone = zone_c;
    next_st.status.charging = next_st.charging;
    next_st.status.boost_on = next_st.boost_on;

    // Interrupt on expiry and on every thermistor fault change.
    ntc_change = next_st.status.thermistor_fault_field !=
                 st.status.thermistor_fault_field;
    next_st.int_ev = (t_expired && st.chg == CHG_RUN) ||
                     ntc_change; // RULE11

    // Register writes; unmapped offsets are ignored.
    if (bus.wr)
    begin
      case (bus.addr)
        CTRL_OFS:
          next_st.ctrl = cst_ctrl_type'(bus.wdata[5:0]);
        ZONE_OFS:
          next_st.zcfg = cst_zone_cfg_type'(bus.wdata[12:0]); // RULE7 RULE18
        default:
          next_st.ctrl = st.ctrl;
      endcase
    end

    // Read data stands for one cycle only; unmapped offsets read zero.
    next_st.rdata = '0;
    if (bus.rd)
    begin
      case (bus.addr)
        CTRL_OFS:
          next_st.rdata = {26'h0, st.ctrl};
        ZONE_OFS:
          next_st.rdata = {19'h0, st.zcfg};
        STAT_OFS:
          next_st.rdata = {16'h0, st.status};
        TIMER_OFS:
          next_st.rdata = {15'h0, t_count};
        default:
          next_st.rdata = '0;
      endcase
    end
  end

  // Whole state in one register; everything else resets to zero.
  // The synchroniser keeps sampling through reset, so the first cycle after
  // release sees real pin levels and reports no false cold zone.
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.sync1 <= pins;
      st.sync2 <= st.sync1;
      st.ctrl <= cst_ctrl_type'(CTRL_RST);
      st.zcfg <= cst_zone_cfg_type'(ZONE_RST); // RULE18
      st.chg <= CHG_IDLE;
      st.iscale <= ISCALE_ZERO;
    end
    else
      st <= next_st;
  end

  cst_safety_timer #(
    .TICK_CYCLES_P (TICK_CYCLES_P)
  ) u_timer (
    .clk     (clk),
    .rstn    (rstn),
    .clear   (t_clear),
    .hold    (t_hold),
    .slow    (t_slow),
    .limit   (t_limit),
    .expired (t_expired),
    .count   (t_count)
  );

  cst_int_pulse #(
    .PULSE_CYCLES_P (PULSE_CYCLES_P)
  ) u_pulse (
    .clk      (clk),
    .rstn     (rstn),
    .event_in (st.int_ev),
    .pulse_n  (host_interrupt_pulse_out_n)
  );

  // Outputs come straight from state flip-flops.
  assign bus_rdata = st.rdata;
  assign drive = '{charging:                   st.charging,
                   iscale:                     st.iscale,
                   programmed_charge_voltage_clamp_4v1:             st.programmed_charge_voltage_clamp_4v1,
                   boost_on:                   st.boost_on,
                   cool_threshold_select:      st.zcfg.cool_threshold_select,
                   warm_threshold_select:      st.zcfg.warm_threshold_select,
                   min_system_voltage_setting:
                     st.zcfg.min_system_voltage_setting};

  start_window_a: // RULE1
    assert property (st.chg == CHG_IDLE && next_st.chg == CHG_RUN
                     |-> win_ok && !st.timer_fault)
    else $error("Charge started outside the window.");

  suspend_zero_a: // RULE2
    assert property (st.chg == CHG_RUN && !win_ok && chg_allowed &&
                     !new_cycle && !t_expired
                     |=> st.chg == CHG_SUSPEND && st.iscale == ISCALE_ZERO)
    else $error("Charging not suspended outside the window.");

  warm_clamp_a: // RULE3
    assert property (st.status.zone == ZONE_WARM
                     |-> st.programmed_charge_voltage_clamp_4v1 ==
                         !$past(st.zcfg.warm_voltage_select))
    else $error("Warm voltage clamp wrong.");

  cool_off_a: // RULE5
    assert property (st.status.zone == ZONE_COOL &&
                     !$past(st.zcfg.cool_current_enable)
                     |-> st.iscale == ISCALE_ZERO)
    else $error("Cool zone current not disabled.");

  boost_suspend_a: // RULE9
    assert property ($past(st.ctrl.boost_enable) && !st.boost_on
                     |-> st.status.input_source_status == SRC_NONE &&
                         st.status.thermistor_fault_field != NTC_NORMAL)
    else $error("Boost suspension not reported.");

  expire_stop_a: // RULE11
    assert property (t_expired && st.chg == CHG_RUN && chg_allowed &&
                     !new_cycle
                     |=> st.chg == CHG_EXPIRED && st.int_ev &&
                         st.status.charge_fault_field == FAULT_TIMER)
    else $error("Expiry did not stop charging.");

  cycle_clear_a: // RULE17
    assert property (new_cycle |=> t_count == '0)
    else $error("Timer not reset on new cycle.");

  allowed_run_a: // RULE21
    assert property (st.chg == CHG_RUN |-> $past(chg_allowed))
    else $error("Charging without enable.");
endmodule

// *** tb/cst_host_model.sv ***
// Host side model that watches the interrupt line and times each pulse.
`timescale 1ns/1ps
module cst_host_model
(
  input  wire logic clk,
  input  wire logic int_n,
  output int        pulses,
  output int        width
);
  int run;

  // Both counters start from zero before the design leaves reset.
  initial
  begin
    pulses = 0;
    width  = 0;
    run    = 0;
  end

  // Whole cycles are counted, so a pulse one cycle off shows up.
  always @(posedge clk)
  begin
    if (int_n === 1'b0)
      run <= run + 1;
    else if (run != 0)
    begin
      pulses <= pulses + 1;
      width  <= run;
      run    <= 0;
    end
  end
endmodule

// *** tb/testbench.sv ***
// Self-checking testbench for the charge supervisor.
`timescale 1ns/1ps
module testbench;
  import cst_pkg::*;
  typedef struct packed {
    logic [5:0]     c;
    logic [12:0]    z;
    logic [3:0]     w;
    logic           g;
    cst_iscale_type s;
    logic           k;
  } cst_row_type;
  logic            clk = 1'b0;
  logic            rstn = 1'b0;
  cst_bus_req_type bus = '0;
  logic [31:0]     bus_rdata;
  cst_pins_type    pins = '0;
  cst_drive_type   drive;
  logic            int_n;
  int              pulses, width, errors = 0, total_checks = 0, n, p0;
  logic [31:0]     d, t0;
  cst_row_type     r;
  // Control, zone setting, comparators, then charging, scale and clamp.
  cst_row_type rows [12] = '{
    '{6'h1f, 13'h1552, 4'h3, 1'b1, ISCALE_FULL,  1'b0},
    '{6'h1f, 13'h1552, 4'h7, 1'b1, ISCALE_FIFTH, 1'b1},
    '{6'h1f, 13'h0a54, 4'h7, 1'b1, ISCALE_HALF,  1'b1},
    '{6'h1f, 13'h1553, 4'h7, 1'b1, ISCALE_FIFTH, 1'b0},
    '{6'h1f, 13'h1550, 4'h7, 1'b1, ISCALE_ZERO,  1'b1},
    '{6'h1f, 13'h1592, 4'h1, 1'b1, ISCALE_HALF,  1'b0},
    '{6'h1f, 13'h155a, 4'h1, 1'b1, ISCALE_FIFTH, 1'b0},
    '{6'h1f, 13'h1572, 4'h1, 1'b1, ISCALE_HALF,  1'b1},
    '{6'h1f, 13'h1542, 4'h1, 1'b1, ISCALE_ZERO,  1'b0},
    '{6'h1f, 13'h1552, 4'hf, 1'b0, ISCALE_ZERO,  1'b0},
    '{6'h1f, 13'h1552, 4'h0, 1'b0, ISCALE_ZERO,  1'b0},
    '{6'h0f, 13'h1552, 4'h7, 1'b1, ISCALE_FULL,  1'b0}};

  // Short tick and pulse counts keep the two-hour limit within reach.
  cst_charge_supervisor #(.TICK_CYCLES_P(4), .PULSE_CYCLES_P(8)) dut_u (
    .clk(clk), .rstn(rstn), .bus(bus), .bus_rdata(bus_rdata),
    .pins(pins), .drive(drive), .host_interrupt_pulse_out_n(int_n));
  cst_host_model host_u (.clk(clk), .int_n(int_n), .pulses(pulses),
    .width(width));

  // A 4 ns clock period.
  always #2 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 v = bus_rdata;
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog sized well above the expected run of about 30000 cycles.
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    close_out();
  end

  // Main sequence: reset checks, then table rows, then the hand-written cases.
  initial
  begin
    pins.vbat_below_programmed_charge_voltage = 1'b1;
    pins.warmer_than = 4'h3;
    pins.boost_warmer = 2'b01;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1 chk("sysmin", 32'(drive.min_system_voltage_setting), 32'h5);
    rd(ZONE_OFS, d);
    chk("zone reg", d, 32'h1552);
    rd(8'h40, d);
    chk("unmapped", d, 32'h0);
    chk("int idle", 32'(int_n), 32'h1);
    $display("test reset done");
    foreach (rows[i])
    begin
      r = rows[i];
      wr(CTRL_OFS, 32'(r.c));
      wr(ZONE_OFS, 32'(r.z));
      pins.warmer_than <= r.w;
      repeat (8) @(posedge clk);
      #1 chk("charging", 32'(drive.charging), 32'(r.g));
      chk("iscale", 32'(drive.iscale), 32'(r.s));
      if (r.g)
        chk("clamp", 32'(drive.programmed_charge_voltage_clamp_4v1), 32'(r.k));
      chk("thresh", 32'({drive.warm_threshold_select,
        drive.cool_threshold_select}), 32'(r.z[9:6]));
    end
    $display("test zone table done");
    wr(CTRL_OFS, 32'h1f);
    pins.warmer_than <= 4'hf;
    pins.charge_enable_pin_low <= 1'b1;
    repeat (6) @(posedge clk);
    pins.charge_enable_pin_low <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk("start hot", 32'(drive.charging), 32'h0);
    pins.warmer_than <= 4'h3;
    repeat (8) @(posedge clk);
    rd(TIMER_OFS, d);
    chk("timer zero", 32'(d < 3), 32'h1);
    pins.ext_fault <= 1'b1;
    repeat (3) @(posedge clk);
    rd(TIMER_OFS, t0);
    repeat (40) @(posedge clk);
    rd(TIMER_OFS, d);
    chk("timer hold", d, t0);
    pins <= '{vindpm: 1'b1, iindpm: 1'b1, sysmin_reg: 1'b1,
      vbat_below_programmed_charge_voltage: 1'b1, warmer_than: 4'h3, boost_warmer: 2'b01,
      default: '0};
    rd(TIMER_OFS, t0);
    repeat (400) @(posedge clk);
    rd(TIMER_OFS, d);
    chk("half rate", 32'((d - t0) inside {[45:56]}), 32'h1);
    wr(CTRL_OFS, 32'h17);
    rd(TIMER_OFS, t0);
    repeat (400) @(posedge clk);
    rd(TIMER_OFS, d);
    chk("full rate", 32'((d - t0) inside {[95:106]}), 32'h1);
    rd(STAT_OFS, d);
    chk("limit flags", 32'(d[10:8]), 32'h7);
    wr(CTRL_OFS, 32'h1d);
    rd(TIMER_OFS, d);
    chk("timer off", d, 32'h0);
    $display("test timer rate done");
    pins.vindpm <= 1'b0;
    pins.iindpm <= 1'b0;
    wr(CTRL_OFS, 32'h1e);
    wr(CTRL_OFS, 32'h1f);
    p0 = pulses;
    repeat (6) @(posedge clk);
    #1;
    // Sampled just after each edge, once the outputs have settled.
    for (n = 0; n < 31000 && drive.charging === 1'b1; n++)
      #4;
    chk("expiry time", 32'(n inside {[28700:28900]}), 32'h1);
    rd(STAT_OFS, d);
    chk("timer fault", 32'(d[1:0]), 32'h3);
    repeat (12) @(posedge clk);
    chk("expiry pulse", 32'(pulses - p0), 32'h1);
    chk("pulse width", 32'(width), 32'h8);
    $display("test expiry done");
    wr(CTRL_OFS, 32'h3e);
    p0 = pulses;
    for (int k = 0; k < 3; k++)
    begin
      pins.boost_warmer <= k == 0 ? 2'b11 : {1'b0, k[1]};
      repeat (12) @(posedge clk);
      rd(STAT_OFS, d);
      chk("boost src", 32'(d[7:2]), k == 0 ? 32'h6 : k == 1 ? 32'h5 :
        32'h38);
      chk("boost on", 32'(drive.boost_on), 32'(k == 2));
    end
    repeat (12) @(posedge clk);
    chk("boost pulses", 32'(pulses - p0), 32'h3);
    $display("test boost done");
    close_out();
  end
endmodule
